//--- logic/bsu_boundary_scan.sv
// Test access port with the 285-cell boundary register and its upper-segment pin gating.
// Assumes the tester drives tms and tdi stable around rising tck edges.
`timescale 1ns/1ps
`include "bsu_defs.svh"
module bsu_boundary_scan #(
  parameter int BSR_LEN = `BSU_BSR_LEN
) (
  // System clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Test port
  input  wire logic                        tck,
  input  wire logic                        trst_n,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output logic                             tdo,
  output logic                             tdo_oe,
  // Boundary cells
  input  wire logic [BSR_LEN-1:0]          cell_capture,
  output logic [BSR_LEN-1:0]               cell_update,
  // Upper-segment pins
  input  wire logic [`BSU_NUM_PINS-1:0]    core_pin_out,
  input  wire logic [`BSU_NUM_PINS-1:0]    core_pin_oe,
  output logic [`BSU_NUM_PINS-1:0]         pin_out,
  output logic [`BSU_NUM_PINS-1:0]         pin_oe,
  // Mode status
  output logic                             test_active,
  output logic                             emu_private_sel,
  output logic                             core_pins_held
);
  import bsu_pkg::*;

  if (BSR_LEN != `BSU_BSR_LEN) begin : g_len_check
    $error("Boundary register length must be 285.");
  end

  typedef struct packed {
    bsu_tap_state_type           state;
    logic [`BSU_IR_LEN-1:0]      ir_shift;
    logic [`BSU_IR_LEN-1:0]      ir;
    logic [BSR_LEN-1:0]          bsr_shift;
    logic [BSR_LEN-1:0]          bsr_upd;
    logic                        byp;
    logic                        tdo;
    logic                        tdo_oe;
    logic                        held;
  } bsu_tap_type;

  bsu_tap_type t_reg;
  bsu_tap_type t_next;

  // No identification or self-test code exists, so every code not listed falls to bypass.
  function automatic bsu_path_type path_of(input logic [`BSU_IR_LEN-1:0] code);
    case (code)
      `BSU_IR_EXTEST, `BSU_IR_SAMPLE, `BSU_IR_INTEST: path_of = PATH_BOUNDARY;
      default:                                        path_of = PATH_BYPASS;
    endcase
  endfunction : path_of

  function automatic logic drives_pins(input logic [`BSU_IR_LEN-1:0] code);
    drives_pins = (code == `BSU_IR_EXTEST) || (code == `BSU_IR_INTEST);
  endfunction : drives_pins

  function automatic logic is_private(input logic [`BSU_IR_LEN-1:0] code);
    is_private = ((code & `BSU_IR_PRIV_MASK) == `BSU_IR_PRIV_CODE);
  endfunction : is_private

  // Pin order: sdram clock 0, row, column, mask, clock enable, A10, dma grant one and two,
  // write, read, sync write, memory selects 0..3, emulator status pin.
  function automatic int out_cell(input int i);
    case (i)
      0:       out_cell = `BSU_CELL_SDRAM_CLOCK_ZERO;
      1:       out_cell = `BSU_CELL_ROW;
      2:       out_cell = `BSU_CELL_COL;
      3:       out_cell = `BSU_CELL_MASK;
      4:       out_cell = `BSU_CELL_CKE;
      5:       out_cell = `BSU_CELL_A10;
      6:       out_cell = `BSU_CELL_DMA_GRANT_ONE;
      7:       out_cell = `BSU_CELL_DMA_GRANT_TWO;
      8:       out_cell = `BSU_CELL_WRITE;
      9:       out_cell = `BSU_CELL_READ;
      10:      out_cell = `BSU_CELL_SYNCW;
      11:      out_cell = `BSU_CELL_MSEL0;
      12:      out_cell = `BSU_CELL_MSEL1;
      13:      out_cell = `BSU_CELL_MSEL2;
      14:      out_cell = `BSU_CELL_MSEL3;
      default: out_cell = `BSU_CELL_EMU_OUT;
    endcase
  endfunction : out_cell

  function automatic int oe_cell(input int i);
    if (i < 6) begin
      oe_cell = `BSU_CELL_SDRAM_OE;
    end else if (i < 15) begin
      oe_cell = `BSU_CELL_STROBE_OE;
    end else begin
      oe_cell = `BSU_CELL_EMU_OE;
    end
  endfunction : oe_cell

  always_comb begin
    t_next        = t_reg;
    t_next.tdo_oe = 1'b0;
    case (t_reg.state)
      TAP_RESET:  t_next.state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:   t_next.state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: t_next.state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: t_next.state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  t_next.state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: t_next.state = tms ? TAP_UP_DR : TAP_PA_DR;
      TAP_PA_DR:  t_next.state = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: t_next.state = tms ? TAP_UP_DR : TAP_SH_DR;
      TAP_UP_DR:  t_next.state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: t_next.state = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: t_next.state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  t_next.state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: t_next.state = tms ? TAP_UP_IR : TAP_PA_IR;
      TAP_PA_IR:  t_next.state = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: t_next.state = tms ? TAP_UP_IR : TAP_SH_IR;
      TAP_UP_IR:  t_next.state = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    t_next.state = TAP_RESET;
    endcase

    case (t_reg.state)
      TAP_RESET: begin
        t_next.ir = `BSU_IR_BYPASS;
      end
      TAP_CAP_IR: begin
        t_next.ir_shift = `BSU_IR_CAPTURE;
      end
      TAP_SH_IR: begin
        // Bit 4 sits nearest TDO and leaves first.
        t_next.ir_shift = {t_reg.ir_shift[`BSU_IR_LEN-2:0], tdi};
        t_next.tdo      = t_reg.ir_shift[`BSU_IR_LEN-1];
        t_next.tdo_oe   = 1'b1;
      end
      TAP_UP_IR: begin
        t_next.ir = t_reg.ir_shift;
      end
      TAP_CAP_DR: begin
        if (path_of(t_reg.ir) == PATH_BOUNDARY) begin
          t_next.bsr_shift = cell_capture;
        end else begin
          t_next.byp = 1'b0;
        end
      end
      TAP_SH_DR: begin
        t_next.tdo_oe = 1'b1;
        if (path_of(t_reg.ir) == PATH_BOUNDARY) begin
          // Cell 0 leaves first and tdi enters at cell 284.
          t_next.bsr_shift = {tdi, t_reg.bsr_shift[BSR_LEN-1:1]};
          t_next.tdo       = t_reg.bsr_shift[0];
        end else begin
          t_next.byp = tdi;
          t_next.tdo = t_reg.byp;
        end
      end
      TAP_UP_DR: begin
        if (path_of(t_reg.ir) == PATH_BOUNDARY) begin
          t_next.bsr_upd = t_reg.bsr_shift;
        end
      end
      default: begin
        t_next.tdo = t_reg.tdo;
      end
    endcase
    // A registered copy of the test ownership feeds the crossing, so a multi-bit IR change
    // cannot glitch into the other clock domain.
    t_next.held = drives_pins(t_next.ir);
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      t_reg       <= '0;
      t_reg.state <= TAP_RESET;
      t_reg.ir    <= `BSU_IR_BYPASS;
    end else begin
      t_reg <= t_next;
    end
  end

  assign tdo             = t_reg.tdo;
  assign tdo_oe          = t_reg.tdo_oe;
  assign cell_update     = t_reg.bsr_upd;
  assign test_active     = drives_pins(t_reg.ir);
  assign emu_private_sel = is_private(t_reg.ir);

  // Pins follow the update latches only while a test owns them; the core keeps them otherwise.
  for (genvar gi = 0; gi < `BSU_NUM_PINS; gi++) begin : g_pin
    assign pin_out[gi] = test_active ? t_reg.bsr_upd[out_cell(gi)] : core_pin_out[gi];
    assign pin_oe[gi]  = test_active ? t_reg.bsr_upd[oe_cell(gi)] : core_pin_oe[gi];
  end

  // The core learns that the test port owns its pins through a level crossing.
  bsu_sync3 u_hold_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (t_reg.held),
    .q      (core_pins_held)
  );

  sequence s_cap_bsr;
    t_reg.state == TAP_CAP_DR && path_of(t_reg.ir) == PATH_BOUNDARY;
  endsequence

  sequence s_shift_bsr;
    t_reg.state == TAP_SH_DR && path_of(t_reg.ir) == PATH_BOUNDARY;
  endsequence

  a_oe_pin_gate: assert property (
    @(posedge tck) disable iff (!trst_n)
    test_active |-> (pin_oe[0] == t_reg.bsr_upd[`BSU_CELL_SDRAM_OE])
                 && (pin_oe[15] == t_reg.bsr_upd[`BSU_CELL_EMU_OE]))
    else $error("Pin enable does not follow its enable cell.");

  a_sdram_group_oe: assert property (
    @(posedge tck) disable iff (!trst_n)
    test_active |-> (pin_oe[5:0] == {6{t_reg.bsr_upd[`BSU_CELL_SDRAM_OE]}}))
    else $error("SDRAM pin group is not gated by one cell.");

  a_strobe_group_oe: assert property (
    @(posedge tck) disable iff (!trst_n)
    test_active |-> (pin_oe[14:6] == {9{t_reg.bsr_upd[`BSU_CELL_STROBE_OE]}}))
    else $error("Strobe pin group is not gated by one cell.");

  a_tdi_end_cell: assert property (
    @(posedge tck) disable iff (!trst_n)
    s_shift_bsr |=> t_reg.bsr_shift[BSR_LEN-1] == $past(tdi))
    else $error("Serial input did not enter the last cell.");

  a_cell0_first: assert property (
    @(posedge tck) disable iff (!trst_n)
    s_cap_bsr ##1 s_shift_bsr |=> t_reg.tdo == $past(cell_capture[0], 2))
    else $error("Cell zero was not shifted out first.");

  a_reset_bypass: assert property (
    @(posedge tck) disable iff (!trst_n)
    t_reg.state == TAP_RESET |=> t_reg.ir == `BSU_IR_BYPASS)
    else $error("Instruction did not load bypass on reset state.");

  a_no_id_path: assert property (
    @(posedge tck) disable iff (!trst_n)
    (t_reg.state == TAP_SH_DR && path_of(t_reg.ir) == PATH_BYPASS)
      |=> t_reg.tdo == $past(t_reg.byp))
    else $error("Unlisted code did not select the bypass cell.");

  a_private_code: assert property (
    @(posedge tck) disable iff (!trst_n)
    is_private(t_reg.ir) |-> emu_private_sel && !test_active)
    else $error("Private code handled as a public test.");

  a_update_latch: assert property (
    @(posedge tck) disable iff (!trst_n)
    (t_reg.state == TAP_UP_DR && path_of(t_reg.ir) == PATH_BOUNDARY)
      |=> t_reg.bsr_upd == $past(t_reg.bsr_shift) ##1 $stable(t_reg.bsr_upd))
    else $error("Update latches did not take the shift stage.");

endmodule : bsu_boundary_scan

//--- common/bsu_defs.svh
// Boundary scan upper segment: cell positions, instruction codes and pin map.
// Assumes a 1149.1 style test port whose instruction bit 0 lies nearest TDI.
//
// Function
// - An output-enable cell holding one in EXTEST or INTEST lets its pins drive, zero releases them.
// - Position 284 is the emulator status output cell at the TDI end, shifted in last.
// - Position 131 is one enable cell gating SDRAM clock 0, strobes, mask, clock enable and A10.
// - Position 153 is one enable cell gating read, write, both DMA grants, selects and sync write.
// - There is no identification register, so no code selects an identification path.
// - There is no built-in self-test reachable through the test port.
// - Codes whose three bits nearest TDO are 001 select private emulation functions.
// - The boundary register is 285 cells, cell zero nearest TDO and shifted out first.
// - The instruction register is five bits, no parity, and loads bypass on test-logic-reset.
`ifndef BSU_DEFS_SVH
`define BSU_DEFS_SVH

`define BSU_BSR_LEN       285
`define BSU_IR_LEN        5
`define BSU_IR_BYPASS     5'h10
`define BSU_IR_CAPTURE    5'h10
`define BSU_IR_EXTEST     5'h00
`define BSU_IR_SAMPLE     5'h01
`define BSU_IR_INTEST     5'h03
`define BSU_IR_PRIV_MASK  5'h1C
`define BSU_IR_PRIV_CODE  5'h04
`define BSU_NUM_PINS      16

`define BSU_CELL_SDRAM_OE 131
`define BSU_CELL_STROBE_OE 153
`define BSU_CELL_EMU_OE   278
`define BSU_CELL_EMU_OUT  284
`define BSU_CELL_SDRAM_CLOCK_ZERO   132
`define BSU_CELL_ROW      137
`define BSU_CELL_COL      139
`define BSU_CELL_MASK     143
`define BSU_CELL_CKE      144
`define BSU_CELL_A10      146
`define BSU_CELL_DMA_GRANT_ONE    148
`define BSU_CELL_DMA_GRANT_TWO    149
`define BSU_CELL_WRITE    157
`define BSU_CELL_READ     159
`define BSU_CELL_SYNCW    163
`define BSU_CELL_MSEL0    171
`define BSU_CELL_MSEL1    173
`define BSU_CELL_MSEL2    175
`define BSU_CELL_MSEL3    177

`endif

//--- common/bsu_pkg.sv
// Types shared by the boundary scan upper segment.
// Assumes bsu_defs.svh supplies the widths.
`include "bsu_defs.svh"
package bsu_pkg;

  // Gray codes along the data-register path.
  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0, TAP_IDLE    = 4'h1, TAP_SEL_DR  = 4'h3, TAP_CAP_DR  = 4'h2,
    TAP_SH_DR   = 4'h6, TAP_EX1_DR  = 4'h7, TAP_PA_DR   = 4'h5, TAP_EX2_DR  = 4'h4,
    TAP_UP_DR   = 4'hC, TAP_SEL_IR  = 4'hD, TAP_CAP_IR  = 4'hF, TAP_SH_IR   = 4'hE,
    TAP_EX1_IR  = 4'hA, TAP_PA_IR   = 4'hB, TAP_EX2_IR  = 4'h9, TAP_UP_IR   = 4'h8
  } bsu_tap_state_type;

  typedef enum logic [1:0] {
    PATH_BYPASS   = 2'h0,
    PATH_BOUNDARY = 2'h1
  } bsu_path_type;

  typedef struct packed {
    logic                        s1;
    logic                        s2;
    logic                        s3;
    logic                        q;
  } bsu_sync_type;

endpackage : bsu_pkg

//--- logic/bsu_sync3.sv
// Three-stage level synchroniser into the clk domain.
// Assumes the input is a slow level from another clock domain.
`timescale 1ns/1ps
module bsu_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Level
  input  wire logic d,
  output logic      q
);
  import bsu_pkg::*;

  bsu_sync_type st_reg;
  bsu_sync_type st_next;

  // The first stage feeds only the second; the output moves once stages two and three agree.
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;
endmodule : bsu_sync3

//--- tb/bsu_tester.sv
// Tester model for the test port: gated 15 ns test clock, mode and data lines.
// Assumes the bench calls one task at a time and nothing else drives the port.
`timescale 1ns/1ps
module bsu_tester (
  // Test port
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck    = 1'b1;
    trst_n = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b1;
    #23.3 trst_n = 1'b1;
  end

  // The clock runs only inside a step and rests high between frames.
  // Within a burst, mode and data change one nanosecond after the previous rising edge.
  // The data line sits at its pull-up level whenever no bit is being sent.
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #6.5 tck = 1'b0;
    #7.5 tck = 1'b1;
    #1 o = tdo;
  endtask : step

  task automatic tms_reset();
    logic o;
    for (int k = 0; k < 6; k++) step(k < 5, 1'b1, o);
  endtask : tms_reset

  task automatic shift_ir(input logic [4:0] code, output logic [4:0] got);
    logic o;
    for (int k = 0; k < 4; k++) step(k < 2, 1'b1, o);
    for (int k = 0; k < 5; k++) begin
      step(k == 4, code[4-k], o);
      got[4-k] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask : shift_ir

  task automatic scan_dr(input logic [284:0] din, input int n, output logic [284:0] dout);
    logic o;
    dout = '0;
    for (int k = 0; k < 3; k++) step(k == 0, 1'b1, o);
    // The bit sent last lands in the cell at the input end.
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], o);
      dout[k] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask : scan_dr
endmodule : bsu_tester

//--- tb/boundary_scan_upper_segment_test.sv
// Self-checking bench for the boundary scan upper segment.
// Assumes the tester model drives the test port and this module drives the rest.
`timescale 1ns/1ps
module boundary_scan_upper_segment_test;
  logic         clk, resetn, tck, trst_n, tms, tdi, tdo, tdo_oe;
  logic         test_active, emu_private_sel, core_pins_held;
  logic [284:0] cell_capture, cell_update, upd;
  logic [15:0]  core_pin_out, core_pin_oe, pin_out, pin_oe;
  int           n_errors, checked, n_oe;
  int           pin_cell[16] = '{132, 137, 139, 143, 144, 146, 148, 149,
                                 157, 159, 163, 171, 173, 175, 177, 284};

  bsu_tester bsu_tester_i (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));

  bsu_boundary_scan bsu_boundary_scan_i (
    .clk(clk), .resetn(resetn), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .cell_capture(cell_capture), .cell_update(cell_update),
    .core_pin_out(core_pin_out), .core_pin_oe(core_pin_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .test_active(test_active), .emu_private_sel(emu_private_sel),
    .core_pins_held(core_pins_held));

  always #4 clk = ~clk;

  // Counts the test clock cycles in which the serial output is enabled.
  always @(posedge tck) begin
    #1 if (tdo_oe === 1'b1) n_oe++;
  end

  task automatic check(input logic [284:0] seen, input logic [284:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic check_pins(input logic [284:0] din, input logic act);
    logic [15:0] eo, ee;
    for (int i = 0; i < 16; i++) begin
      eo[i] = din[pin_cell[i]];
      ee[i] = din[i < 6 ? 131 : i < 15 ? 153 : 278];
    end
    check(pin_out, act ? eo : core_pin_out);
    check(pin_oe, act ? ee : core_pin_oe);
  endtask : check_pins

  task automatic t_after_reset();
    logic [4:0]   ir;
    logic [284:0] dout;
    check(test_active, 1'b0);
    check_pins('0, 1'b0);
    bsu_tester_i.shift_ir(5'h10, ir);
    check(ir, 5'h10);
    bsu_tester_i.scan_dr(285'hB5, 8, dout);
    check(dout[7:0], 8'h6A);
    check(n_oe, 13);
    $display("t_after_reset done");
  endtask : t_after_reset

  task automatic t_extest();
    logic [4:0]   ir;
    logic [284:0] a, dout;
    for (int i = 0; i < 285; i++) a[i] = i[0] ^ i[2];
    a[131] = 1'b1;
    a[153] = 1'b0;
    a[278] = 1'b1;
    a[284] = 1'b1;
    bsu_tester_i.shift_ir(5'h00, ir);
    check(test_active, 1'b1);
    repeat (6) @(posedge clk);
    #1 check(core_pins_held, 1'b1);
    // The second pass inverts every enable so both drive and release are seen.
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      #1 cell_capture = ~cell_capture;
      bsu_tester_i.scan_dr(a, 285, dout);
      check(dout, cell_capture);
      check(cell_update, a);
      check_pins(a, 1'b1);
      upd = a;
      a = ~a;
    end
    $display("t_extest done");
  endtask : t_extest

  task automatic t_codes();
    logic [4:0]   ir;
    logic [284:0] dout;
    logic         act;
    for (int c = 0; c < 32; c++) begin
      act = (c == 0) || (c == 3);
      bsu_tester_i.shift_ir(c[4:0], ir);
      check(test_active, act);
      check(emu_private_sel, c[4:2] == 3'b001);
      check_pins(upd, act);
      if (c != 0 && c != 1 && c != 3) begin
        bsu_tester_i.scan_dr(285'h5B, 8, dout);
        check(dout[7:0], 8'hB6);
      end
    end
    $display("t_codes done");
  endtask : t_codes

  task automatic t_tms_reset();
    logic [4:0] ir;
    bsu_tester_i.shift_ir(5'h03, ir);
    bsu_tester_i.tms_reset();
    check(test_active, 1'b0);
    check_pins(upd, 1'b0);
    repeat (6) @(posedge clk);
    #1 check(core_pins_held, 1'b0);
    $display("t_tms_reset done");
  endtask : t_tms_reset

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial begin
    clk          = 1'b0;
    resetn       = 1'b0;
    n_errors     = 0;
    checked      = 0;
    n_oe         = 0;
    upd          = '0;
    core_pin_out = 16'hA5C3;
    core_pin_oe  = 16'h0FF0;
    for (int i = 0; i < 285; i++) cell_capture[i] = (i % 3 == 0);
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    bsu_tester_i.tms_reset();
    t_after_reset();
    t_extest();
    t_codes();
    t_tms_reset();
    give_verdict();
  end
endmodule : boundary_scan_upper_segment_test
